// *** tie_enable_regs.sv ***
// Overview of operation
// - Bit 6 always reads one; software writes only one there.
// - Channels 1,2: bit 5 underflow enable, resets zero, gates underflow request.
// - Channels 0,3,4: bit 5 reserved, reads zero, software writes zero.
// - Bit 4 overflow enable on every channel, resets zero, gates overflow request.
// - Channels 0,3,4: bit 3 compare-D enable, resets zero, gates compare-D request.
// - Channels 1,2: bit 3 reserved, reads zero, software writes zero.
// - A/D trigger enable one permits start requests, zero prevents them.
// - A/D enable is bit 7, resets zero, fires on register A capture/match.
//
// Added by the designer: the address map and register access over Avalon-MM.
`default_nettype none
module tie_enable_regs
  import tie_pkg::*;
#(
  parameter int CHANNEL = 1
)(
  input  wire logic        sys_clk,        // 250 MHz clock
  input  wire logic        reset,          // Synchronous, active high
  input  wire logic [3:0]  avsAddress,     // Byte address
  input  wire logic        avsRead,        // Read request
  input  wire logic        avsWrite,       // Write request
  input  wire logic [31:0] avsWriteData,   // Write data
  input  wire logic [3:0]  avsByteEnable,  // Byte lanes
  output logic      [31:0] avsReadData,    // Read data
  output logic             avsWaitRequest, // Stall
  input  wire tie_flags_t  flags,          // Status flags
  input  wire logic        captureMatchA,  // Register A capture/compare pulse
  output tie_req_t         requests,       // Interrupt requests
  output logic             adcStartReq,    // A/D conversion start request
  output logic             irq             // Level interrupt
);

  localparam bit HAS_UF = (CHANNEL == 1) || (CHANNEL == 2);

  // Only implemented enable bits hold state; reserved ones stay constant
  localparam logic [7:0] WR_MASK = 8'h90 | (HAS_UF ? 8'h20 : 8'h08);

  logic [7:0]           enableFf;
  logic [EVT_WIDTH-1:0] statusFf;
  logic [EVT_WIDTH-1:0] maskFf;
  logic                 ackFf;
  logic [31:0]          readDataFf;
  logic [EVT_WIDTH-1:0] events;
  logic                 wrAccept;
  logic                 rdStart;

  function automatic logic [7:0] enableView(input logic [7:0] stored);
    enableView = (stored & WR_MASK) | RSV_ONE_VAL;
  endfunction

  // Shared by every register write and by some of the write checks below; p_uf_gate and p_ov_block spell out the same terms
  function automatic logic wrHit(input logic [3:0] off);
    wrHit = wrAccept && avsAddress == off && avsByteEnable[0];
  endfunction

  // Every access takes exactly one wait cycle
  assign avsWaitRequest = (avsRead || avsWrite) && !ackFf;
  assign wrAccept       = avsWrite && ackFf;
  assign rdStart        = avsRead && !ackFf;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      ackFf <= 1'b0;
    else
      ackFf <= (avsRead || avsWrite) && !ackFf;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      enableFf <= ENABLE_RESET;
    else if (wrHit(OFF_ENABLE))
      enableFf <= avsWriteData[7:0] & WR_MASK;
  end

  // Requests follow flag and enable without a register stage
  // One driver for the whole struct, so no tool sees the port written in parts
  assign requests = '{
    underflow: flags.underflow && enableFf[BIT_UNDERFLOW] && HAS_UF,
    overflow:  flags.overflow && enableFf[BIT_OVERFLOW],
    compareD:  flags.compareD && enableFf[BIT_COMPARE_D] && !HAS_UF
  };
  assign adcStartReq        = captureMatchA && enableFf[BIT_ADC_TRIG];

  assign events = {adcStartReq, requests.compareD, requests.overflow, requests.underflow};

  // A new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      statusFf <= STATUS_RESET;
    else if (wrHit(OFF_STATUS))
      statusFf <= (statusFf & ~avsWriteData[EVT_WIDTH-1:0]) | events;
    else
      statusFf <= statusFf | events;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      maskFf <= MASK_RESET;
    else if (wrHit(OFF_MASK))
      maskFf <= avsWriteData[EVT_WIDTH-1:0];
  end

  assign irq = |(statusFf & maskFf);

  // Unmapped offsets read as zero and ignore writes
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      readDataFf <= 32'h0;
    else if (rdStart)
    begin
      unique case (avsAddress)
        OFF_ENABLE: readDataFf <= {24'h0, enableView(enableFf)};
        OFF_STATUS: readDataFf <= {28'h0, statusFf};
        OFF_MASK:   readDataFf <= {28'h0, maskFf};
        default:    readDataFf <= 32'h0;
      endcase
    end
  end

  assign avsReadData = readDataFf;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  logic rdEnDone;
  assign rdEnDone = avsRead && !avsWaitRequest && avsAddress == OFF_ENABLE;

  property p_rsv_one;
    rdEnDone |-> avsReadData[BIT_RSV_ONE];
  endproperty
  a_rsv_one: assert property (p_rsv_one) else $error("bit 6 read as zero");

  property p_uf_gate;
    (wrAccept && avsAddress == OFF_ENABLE && avsByteEnable[0]
      && avsWriteData[BIT_UNDERFLOW] && HAS_UF)
      ##1 flags.underflow |-> requests.underflow;
  endproperty
  a_uf_gate: assert property (p_uf_gate) else $error("underflow request missing");

  property p_rsv_uf;
    (rdEnDone && !HAS_UF) |-> !avsReadData[BIT_UNDERFLOW];
  endproperty
  a_rsv_uf: assert property (p_rsv_uf) else $error("reserved bit 5 read as one");

  property p_ov_block;
    (wrAccept && avsAddress == OFF_ENABLE && avsByteEnable[0]
      && !avsWriteData[BIT_OVERFLOW]) ##1 !avsWrite[*2] |-> !requests.overflow;
  endproperty
  a_ov_block: assert property (p_ov_block) else $error("overflow request not blocked");

  property p_cd_gate;
    (!HAS_UF && flags.compareD && enableFf[BIT_COMPARE_D]) |-> requests.compareD
      ##1 (statusFf[EVT_COMPARE_D]);
  endproperty
  a_cd_gate: assert property (p_cd_gate) else $error("compare-D event lost");

  property p_rsv_cd;
    (rdEnDone && HAS_UF) |-> !avsReadData[BIT_COMPARE_D];
  endproperty
  a_rsv_cd: assert property (p_rsv_cd) else $error("reserved bit 3 read as one");

  property p_adc_off;
    !enableFf[BIT_ADC_TRIG] |-> !adcStartReq;
  endproperty
  a_adc_off: assert property (p_adc_off) else $error("A/D start while disabled");

  property p_adc_reset;
    $fell(reset) |-> !enableFf[BIT_ADC_TRIG] && !adcStartReq;
  endproperty
  a_adc_reset: assert property (@(posedge sys_clk) p_adc_reset)
    else $error("A/D enable not cleared by reset");

  property p_req_drop;
    wrHit(OFF_ENABLE) && !avsWriteData[BIT_OVERFLOW] |=> !requests.overflow;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request kept after disable");

  property p_wait_one;
    (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");

  property p_sticky;
    (statusFf[EVT_OVERFLOW] && !wrAccept) |=> statusFf[EVT_OVERFLOW];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit lost");

  property p_uf_off;
    !enableFf[BIT_UNDERFLOW] |-> !requests.underflow;
  endproperty
  a_uf_off: assert property (p_uf_off)
    else $error("underflow request while disabled");

  property p_uf_follow;
    (HAS_UF && flags.underflow && enableFf[BIT_UNDERFLOW]) |-> requests.underflow;
  endproperty
  a_uf_follow: assert property (p_uf_follow)
    else $error("underflow request not raised");

  property p_uf_store_rsv;
    !HAS_UF |-> !enableFf[BIT_UNDERFLOW];
  endproperty
  a_uf_store_rsv: assert property (p_uf_store_rsv)
    else $error("reserved bit 5 stored");

  property p_ov_gate;
    (flags.overflow && enableFf[BIT_OVERFLOW]) |-> requests.overflow;
  endproperty
  a_ov_gate: assert property (p_ov_gate)
    else $error("overflow request not raised");

  property p_ov_off;
    !enableFf[BIT_OVERFLOW] |-> !requests.overflow;
  endproperty
  a_ov_off: assert property (p_ov_off)
    else $error("overflow request while disabled");

  property p_cd_off;
    !enableFf[BIT_COMPARE_D] |-> !requests.compareD;
  endproperty
  a_cd_off: assert property (p_cd_off)
    else $error("compare-D request while disabled");

  property p_cd_store_rsv;
    HAS_UF |-> !enableFf[BIT_COMPARE_D];
  endproperty
  a_cd_store_rsv: assert property (p_cd_store_rsv)
    else $error("reserved bit 3 stored");

  property p_adc_on;
    (enableFf[BIT_ADC_TRIG] && captureMatchA) |-> adcStartReq;
  endproperty
  a_adc_on: assert property (p_adc_on)
    else $error("A/D start missing while enabled");

  property p_adc_store;
    wrHit(OFF_ENABLE) |=> enableFf[BIT_ADC_TRIG] == $past(avsWriteData[BIT_ADC_TRIG]);
  endproperty
  a_adc_store: assert property (p_adc_store)
    else $error("A/D enable not written");

  // Checked through reset itself, so the default disable must not apply
  property p_reset_clear;
    @(posedge sys_clk) disable iff (1'b0)
      reset |=> enableFf == ENABLE_RESET && maskFf == MASK_RESET;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("registers not cleared by reset");

  property p_rd_upper;
    rdEnDone |-> avsReadData[31:8] == 24'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("enable read upper bits not zero");

  // Set wins over clear, so an unmasked event shows next cycle unless a mask write in the same cycle clears its bit
  property p_irq_set;
    (|(events & maskFf)) |=> irq;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("irq not raised by event");

  property p_mask_keep;
    !wrHit(OFF_MASK) |=> $stable(maskFf);
  endproperty
  a_mask_keep: assert property (p_mask_keep)
    else $error("mask changed without write");

  property p_en_keep;
    !wrHit(OFF_ENABLE) |=> $stable(enableFf);
  endproperty
  a_en_keep: assert property (p_en_keep)
    else $error("enable changed without write");

  property p_ack_pulse;
    ackFf |=> !ackFf;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("acknowledge longer than one cycle");

  property p_wait_first;
    $rose(avsRead) |-> avsWaitRequest;
  endproperty
  a_wait_first: assert property (p_wait_first)
    else $error("read answered without wait cycle");

  property p_sticky_uf;
    (statusFf[EVT_UNDERFLOW] && !wrHit(OFF_STATUS)) |=> statusFf[EVT_UNDERFLOW];
  endproperty
  a_sticky_uf: assert property (p_sticky_uf)
    else $error("underflow status bit lost");

  c_ov_irq:  cover property (requests.overflow ##1 irq);
  c_uf_req:  cover property (requests.underflow);
  c_cd_req:  cover property (requests.compareD);
  c_adc_req: cover property (adcStartReq ##1 irq);
  c_rd_en:   cover property (rdEnDone);

endmodule
`default_nettype wire

// *** tie_pkg.sv ***
`default_nettype none
package tie_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] OFF_ENABLE = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_MASK   = 4'h8;

  // Enable register field positions
  localparam int BIT_ADC_TRIG   = 7;
  localparam int BIT_RSV_ONE    = 6;
  localparam int BIT_UNDERFLOW  = 5;
  localparam int BIT_OVERFLOW   = 4;
  localparam int BIT_COMPARE_D  = 3;

  // Event status / mask layout
  localparam int EVT_UNDERFLOW  = 0;
  localparam int EVT_OVERFLOW   = 1;
  localparam int EVT_COMPARE_D  = 2;
  localparam int EVT_ADC_START  = 3;
  localparam int EVT_WIDTH      = 4;

  // Reset values
  localparam logic [7:0]           ENABLE_RESET = 8'h00;
  localparam logic [EVT_WIDTH-1:0] STATUS_RESET = 4'h0;
  localparam logic [EVT_WIDTH-1:0] MASK_RESET   = 4'h0;
  localparam logic [7:0]           RSV_ONE_VAL  = 8'h40;

  // Flags from the timer status register
  typedef struct packed {
    logic underflow;
    logic overflow;
    logic compareD;
  } tie_flags_t;

  // Interrupt requests toward the interrupt controller
  typedef struct packed {
    logic underflow;
    logic overflow;
    logic compareD;
  } tie_req_t;
endpackage
`default_nettype wire

// *** timer_interrupt_enable_bits_tb_top.sv ***
`default_nettype none
module timer_interrupt_enable_bits_tb_top
  import tie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CH = 1;
  logic        clk, rst, rd, wr, capA, waitReq, adcReq, irq;
  logic [3:0]  addr, be;
  logic [31:0] wdata, rdata, got;
  logic [7:0]  en;
  tie_flags_t  flags;
  tie_req_t    req;
  int          errCount, checksDone;

  tie_enable_regs #(.CHANNEL(CH)) dut (.sys_clk(clk), .reset(rst), .avsAddress(addr),
    .avsRead(rd), .avsWrite(wr), .avsWriteData(wdata), .avsByteEnable(be),
    .avsReadData(rdata), .avsWaitRequest(waitReq), .flags(flags), .captureMatchA(capA),
    .requests(req), .adcStartReq(adcReq), .irq(irq));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checksDone++;
    if (seen !== exp)
    begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One idle edge first, so a release and a new request never share a time step
  task automatic busDo(input logic isWr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] lanes);
    int n = 0;
    @(posedge clk);
    rd <= ~isWr;
    wr <= isWr;
    addr <= a;
    wdata <= d;
    be <= lanes;
    @(posedge clk);
    while (waitReq !== 1'b0 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 50)
      check("bus answer", 32'h0, 32'h1);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  function automatic logic [7:0] view(input logic [7:0] d);
    logic [7:0] m;
    m = (CH == 1 || CH == 2) ? 8'hB0 : 8'h98;
    return (d & m) | RSV_ONE_VAL;
  endfunction

  function automatic logic [31:0] expReq(input logic [7:0] d, input tie_flags_t f);
    logic [7:0] v;
    v = view(d);
    return {29'h0, f.underflow & v[BIT_UNDERFLOW], f.overflow & v[BIT_OVERFLOW],
            f.compareD & v[BIT_COMPARE_D]};
  endfunction

  initial
  begin
    repeat (20000) @(posedge clk);
    errCount++;
    report_and_stop();
  end

  initial
  begin
    rst = 1'b1; rd = 1'b0; wr = 1'b0; addr = 4'h0; wdata = 32'h0; be = 4'hF;
    flags = '0; capA = 1'b0; errCount = 0; checksDone = 0; en = 8'h00;
    void'($urandom(99));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    busDo(1'b0, OFF_ENABLE, 32'h0, 4'hF); check("enable reset", 32'h40, got);
    for (int i = 3; i >= 0; i--)
    begin
      busDo(1'b0, 4'(4 * i), 32'h0, 4'hF);
      if (i > 0) check("reset or unmapped", 32'h0, got);
    end
    for (int i = 3; i >= 0; i--)
    begin
      en = view((i % 2 == 0) ? 8'hFF : 8'h00);
      busDo(1'b1, OFF_ENABLE, {24'h0, en}, (i == 3) ? 4'hE : 4'hF);
      busDo(1'b0, OFF_ENABLE, 32'h0, 4'hF);
      check("enable view", {24'h0, view((i == 3) ? 8'h00 : en)}, got);
    end
    for (int i = 0; i < 40; i++)
    begin
      en = view((i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom));
      busDo(1'b1, OFF_ENABLE, {24'h0, en}, 4'hF);
      @(posedge clk);
      flags <= (i < 2) ? 3'h7 : 3'($urandom);
      capA <= (i < 2) ? 1'b1 : 1'($urandom);
      @(negedge clk);
      check("requests", expReq(en, flags), 32'(req));
      check("adc start", {31'h0, capA & en[BIT_ADC_TRIG]}, {31'h0, adcReq});
      check("irq masked", 32'h0, {31'h0, irq});
      @(posedge clk);
      flags <= '0;
      capA <= 1'b0;
    end
    busDo(1'b1, OFF_STATUS, 32'hF, 4'hF);
    busDo(1'b1, OFF_ENABLE, 32'h50, 4'hF);
    busDo(1'b0, OFF_STATUS, 32'h0, 4'hF); check("status cleared", 32'h0, got);
    @(posedge clk);
    flags <= 3'b010;
    @(posedge clk);
    flags <= '0;
    busDo(1'b0, OFF_STATUS, 32'h0, 4'hF); check("status set", 32'h2, got);
    busDo(1'b1, OFF_MASK, 32'h2, 4'hF);
    @(negedge clk); check("irq raised", 32'h1, {31'h0, irq});
    busDo(1'b1, OFF_STATUS, 32'h1, 4'hF);
    @(negedge clk); check("irq kept", 32'h1, {31'h0, irq});
    busDo(1'b1, OFF_STATUS, 32'h2, 4'hF);
    @(negedge clk); check("irq cleared", 32'h0, {31'h0, irq});
    busDo(1'b0, OFF_MASK, 32'h0, 4'hF); check("mask", 32'h2, got);
    report_and_stop();
  end
endmodule
`default_nettype wire
